/* src/txe_regs.svh */
// register offsets, field positions, reset values and generator seed for the transmit encoder
// Function
// - async mode passes the synchronised data line straight to the modulator.
// - async mode drives the clock output as a divided host clock or time base.
// - gaussian and amplitude shaping stay selectable in async mode.
// - sync mode times every bit from the device's own divider.
// - sync mode raises the clock output to request each next bit.
// - line encoding is applied in sync mode.
// - encoder offers Manchester, diff Manchester, bi-phase space/mark, Miller, NRZ, PRBS9.
// - every encoded format can be level inverted.
// - a nine-stage generator yields pseudo-random test patterns.
// - status flags brownout, lock error, calibration error and parity error.
// - each configuration write stores a parity bit of the written value.
// - while transmitting, parity of each configuration register is rechecked continuously.
// - parity mismatch without a write sets the parity error flag.
// - any failure switches the power amplifier off.
`ifndef TXE_REGS_SVH
`define TXE_REGS_SVH
`define TXE_CFG_N        4
`define TXE_OFS_CTRL     3'h0
`define TXE_OFS_ENC      3'h1
`define TXE_OFS_BITDIV   3'h2
`define TXE_OFS_CLKDIV   3'h3
`define TXE_OFS_STATUS   3'h4
`define TXE_OFS_MASK     3'h5
`define TXE_OFS_STATE    3'h6
`define TXE_CTRL_TXEN    0
`define TXE_CTRL_SYNC    1
`define TXE_CTRL_GAUSS   2
`define TXE_CTRL_ASK     3
`define TXE_CTRL_CKEN    4
`define TXE_ENC_INV      3
`define TXE_STS_BROWN    0
`define TXE_STS_LOCK     1
`define TXE_STS_CAL      2
`define TXE_STS_PAR      3
`define TXE_RST_CFG      8'h00
`define TXE_RST_DIV      8'h07
`define TXE_PRBS_SEED    9'h1ff
`endif

/* src/txe_pkg.sv */
// types shared by the transmit encoder modules
package txe_pkg;
   typedef enum logic [2:0] {
      TXE_NRZ   = 3'h0,
      TXE_MAN   = 3'h1,
      TXE_DMAN  = 3'h2,
      TXE_BPS   = 3'h3,
      TXE_BPM   = 3'h4,
      TXE_MIL   = 3'h5,
      TXE_PRBS  = 3'h6
   } txe_code_t;
   typedef enum logic [3:0] {
      TXE_IDLE  = 4'h1,
      TXE_ASYNC = 4'h2,
      TXE_SYNC  = 4'h4,
      TXE_HALT  = 4'h8
   } txe_state_t;
   typedef struct packed {
      logic       invert;
      txe_code_t  code;
   } txe_enc_t;
endpackage : txe_pkg

/* src/txe_encoder.sv */
// line encoder: one NRZ bit in, two chips out
`timescale 1ns/1ns
`include "txe_regs.svh"
module txe_encoder (
   // clock and reset
   input  wire logic           clock,
   input  wire logic           rst,
   // chip timing
   input  wire logic           clr,
   input  wire logic           chip_en,
   input  wire logic           first,
   // data and format
   input  wire logic           bit_in,
   input  wire txe_pkg::txe_enc_t enc,
   output logic                chip_out
);
   logic       lvl;
   logic       cur_b;
   logic       prev_b;
   logic [8:0] prbs;
   logic       f_chip;
   logic       s_chip;
   logic       raw;
   wire        b  = first ? bit_in : cur_b;
   wire        fb = prbs[8] ^ prbs[4];
   // first-half chip per format
   always_comb
   begin
      unique case (enc.code)
         txe_pkg::TXE_MAN:  f_chip = b;
         txe_pkg::TXE_DMAN: f_chip = b ? lvl : ~lvl;
         txe_pkg::TXE_BPS,
         txe_pkg::TXE_BPM:  f_chip = ~lvl;
         txe_pkg::TXE_MIL:  f_chip = (~b & ~prev_b) ? ~lvl : lvl;
         txe_pkg::TXE_PRBS: f_chip = b ^ prbs[8];
         default:           f_chip = b;
      endcase
   end
   // second-half chip: mid transition decides the code
   always_comb
   begin
      unique case (enc.code)
         txe_pkg::TXE_MAN,
         txe_pkg::TXE_DMAN: s_chip = ~lvl;
         txe_pkg::TXE_BPS:  s_chip = b ? lvl : ~lvl;
         txe_pkg::TXE_BPM,
         txe_pkg::TXE_MIL:  s_chip = b ? ~lvl : lvl;
         txe_pkg::TXE_PRBS: s_chip = lvl;
         default:           s_chip = b;
      endcase
   end
   assign raw = first ? f_chip : s_chip;
   // lvl tracks the uninverted line so differential codes stay right
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lvl      <= 1'b0;
         cur_b    <= 1'b0;
         prev_b   <= 1'b1;
         prbs     <= `TXE_PRBS_SEED;
         chip_out <= 1'b0;
      end
      else if (clr)
      begin
         lvl      <= 1'b0;
         prev_b   <= 1'b1;
         prbs     <= `TXE_PRBS_SEED;
         chip_out <= enc.invert;
      end
      else if (chip_en)
      begin
         lvl      <= raw;
         chip_out <= raw ^ enc.invert;
         if (first)
         begin
            cur_b <= bit_in;
            prbs  <= {prbs[7:0], fb};
         end
         else
            prev_b <= cur_b;
      end
   end
   chk_manch_mid : assert property (@(posedge clock) disable iff (rst)
      (!clr && chip_en && !first && enc.code == txe_pkg::TXE_MAN)
      |=> chip_out != $past(chip_out))
      else $error("manchester chip pair lacks mid transition");
endmodule : txe_encoder

/* src/txe_top.sv */
// transmit data path: register port, bit timing, encoder, fail-safe monitor
`timescale 1ns/1ns
`include "txe_regs.svh"
module txe_top #(
   parameter int DIV_W = 8
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // register port
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // host pins
   input  wire logic       sdio_in,
   output logic            clock_output_pin,
   // failure sources
   input  wire logic       brownout_in,
   input  wire logic       lock_err_in,
   input  wire logic       cal_err_in,
   input  wire logic       cfg_upset_in,
   // modulator, amplifier and interrupt
   output logic            mod_data,
   output logic            gauss_en,
   output logic            ask_shape_en,
   output logic            pa_enable,
   output logic            irq
);
   if (DIV_W < 2 || DIV_W > 8)
      $error("DIV_W must be 2..8");

   // two-stage synchronisers for all pin inputs
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic       upset_d;
   wire  [4:0] pin_raw = {cfg_upset_in, cal_err_in, lock_err_in, brownout_in, sdio_in};
   wire        sdio_s  = pin_s2[0];
   wire  [2:0] hw_err  = pin_s2[3:1];
   wire        upset   = pin_s2[4] & ~upset_d;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pin_s1  <= 5'h00;
         pin_s2  <= 5'h00;
         upset_d <= 1'b0;
      end
      else
      begin
         pin_s1  <= pin_raw;
         pin_s2  <= pin_s1;
         upset_d <= pin_s2[4];
      end
   end

   // configuration registers with stored parity
   logic [7:0] cfg [`TXE_CFG_N];
   logic [`TXE_CFG_N-1:0] par;
   logic [`TXE_CFG_N-1:0] par_bad;
   logic       tx_act;
   wire        cfg_wr = wr && (addr < 3'(`TXE_CFG_N));
   genvar g;
   for (g = 0; g < `TXE_CFG_N; g++)
   begin : g_cfg
      wire hit = cfg_wr && (addr == 3'(g));
      // upset models a corrupting event on the low bit of the last register (clock divider) only
      wire hit_upset = upset && (g == `TXE_CFG_N - 1);
      always_ff @(posedge clock or posedge rst)
      begin
         if (rst)
         begin
            cfg[g] <= (g >= 2) ? `TXE_RST_DIV : `TXE_RST_CFG;
            par[g] <= (g >= 2) ? ^`TXE_RST_DIV : ^`TXE_RST_CFG;
         end
         else if (hit)
         begin
            cfg[g] <= wdata;
            par[g] <= ^wdata;
         end
         else if (hit_upset)
            cfg[g] <= cfg[g] ^ 8'h01;
      end
      assign par_bad[g] = tx_act && (par[g] != ^cfg[g]);
   end

   wire                 tx_en   = cfg[0][`TXE_CTRL_TXEN];
   wire                 sync_md = cfg[0][`TXE_CTRL_SYNC];
   wire                 ck_en   = cfg[0][`TXE_CTRL_CKEN];
   wire txe_pkg::txe_enc_t enc  = txe_pkg::txe_enc_t'(cfg[1][3:0]);
   wire [DIV_W-1:0]     bitdiv  = cfg[2][DIV_W-1:0];
   wire [DIV_W-1:0]     clkdiv  = cfg[3][DIV_W-1:0];

   // status, mask and interrupt
   logic [3:0] sts;
   logic [3:0] mask;
   wire  [3:0] ev      = {|par_bad, hw_err};
   wire        sts_wr  = wr && (addr == `TXE_OFS_STATUS);
   wire  [3:0] w1c     = sts_wr ? wdata[3:0] : 4'h0;
   wire  [3:0] next_sts = (sts & ~w1c) | ev;
   wire        fail    = |sts;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sts  <= 4'h0;
         mask <= 4'h0;
         irq  <= 1'b0;
      end
      else
      begin
         sts  <= next_sts;
         irq  <= |(next_sts & mask);
         if (wr && addr == `TXE_OFS_MASK)
            mask <= wdata[3:0];
      end
   end

   // transmit state machine
   txe_pkg::txe_state_t state;
   txe_pkg::txe_state_t next_state;
   always_comb
   begin
      next_state = state;
      unique case (state)
         txe_pkg::TXE_IDLE:
            if (tx_en && !fail)
               next_state = sync_md ? txe_pkg::TXE_SYNC : txe_pkg::TXE_ASYNC;
         txe_pkg::TXE_ASYNC:
            if (fail)
               next_state = txe_pkg::TXE_HALT;
            else if (!tx_en || sync_md)
               next_state = txe_pkg::TXE_IDLE;
         txe_pkg::TXE_SYNC:
            if (fail)
               next_state = txe_pkg::TXE_HALT;
            else if (!tx_en || !sync_md)
               next_state = txe_pkg::TXE_IDLE;
         txe_pkg::TXE_HALT:
            if (!fail && !tx_en)
               next_state = txe_pkg::TXE_IDLE;
      endcase
   end
   assign tx_act = (state == txe_pkg::TXE_ASYNC) || (state == txe_pkg::TXE_SYNC);
   wire in_sync  = state == txe_pkg::TXE_SYNC;
   wire in_async = state == txe_pkg::TXE_ASYNC;

   // device-timed chips: one chip every bitdiv+1 clocks, two per bit
   logic [DIV_W-1:0] chip_cnt;
   logic             half;
   logic             nxt_bit;
   wire              chip_en = in_sync && (chip_cnt == bitdiv);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         chip_cnt <= '0;
         half     <= 1'b0;
         nxt_bit  <= 1'b0;
      end
      else if (!in_sync)
      begin
         chip_cnt <= '0;
         half     <= 1'b0;
      end
      else
      begin
         chip_cnt <= chip_en ? '0 : chip_cnt + 1'b1;
         if (chip_en)
            half <= ~half;
         // sampled half a bit after the request
         if (chip_en && !half)
            nxt_bit <= sdio_s;
      end
   end

   // encoder runs only in device-timed mode
   logic enc_chip;
   txe_encoder u_enc (
      .clock    (clock),
      .rst      (rst),
      .clr      (!in_sync),
      .chip_en  (chip_en),
      .first    (!half),
      .bit_in   (nxt_bit),
      .enc      (enc),
      .chip_out (enc_chip)
   );

   // clock output divider, free for the host outside sync mode
   logic [DIV_W-1:0] ck_cnt;
   logic             next_ck;
   wire              ck_tick = ck_en && (ck_cnt == clkdiv);
   always_comb
   begin
      next_ck = clock_output_pin;
      if (in_sync)
      begin
         if (chip_en)
            next_ck = half;
      end
      else if (!ck_en)
         next_ck = 1'b0;
      else if (ck_tick)
         next_ck = ~clock_output_pin;
   end

   // registered outputs
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ck_cnt           <= '0;
         clock_output_pin <= 1'b0;
         mod_data         <= 1'b0;
         gauss_en         <= 1'b0;
         ask_shape_en     <= 1'b0;
         pa_enable        <= 1'b0;
         state            <= txe_pkg::TXE_IDLE;
      end
      else
      begin
         ck_cnt           <= (ck_tick || !ck_en) ? '0 : ck_cnt + 1'b1;
         clock_output_pin <= next_ck;
         state            <= next_state;
         pa_enable        <= tx_act && !fail && (next_state == state);
         gauss_en         <= cfg[0][`TXE_CTRL_GAUSS];
         ask_shape_en     <= cfg[0][`TXE_CTRL_ASK];
         if (in_async)
            mod_data <= sdio_s;
         else if (in_sync)
            mod_data <= enc_chip;
         else
            mod_data <= 1'b0;
      end
   end

   // register read, data one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (addr < 3'(`TXE_CFG_N))
         rd_mux = cfg[addr[1:0]];
      else if (addr == `TXE_OFS_STATUS)
         rd_mux = {4'h0, sts};
      else if (addr == `TXE_OFS_MASK)
         rd_mux = {4'h0, mask};
      else if (addr == `TXE_OFS_STATE)
         rd_mux = {2'h0, pa_enable, clock_output_pin, state};
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else
         rdata <= rd ? rd_mux : 8'h00;
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);

   chk_async_pass : assert property (in_async |=> mod_data == $past(sdio_s))
      else $error("async data not passed through");
   chk_clk_toggle : assert property (!in_sync && ck_tick |=> clock_output_pin != $past(clock_output_pin))
      else $error("clock output did not toggle on divider");
   chk_bit_request : assert property (chip_en && half && bitdiv != '0 |=> clock_output_pin ##1 clock_output_pin)
      else $error("bit request not raised");
   chk_chip_spacing : assert property (chip_en && bitdiv != '0 |=> !chip_en)
      else $error("chip enable not spaced");
   chk_parity_store : assert property (cfg_wr |=> par[$past(addr[1:0])] == ^$past(wdata))
      else $error("parity not stored on write");
   chk_parity_flag : assert property (|par_bad |=> sts[`TXE_STS_PAR])
      else $error("parity mismatch not flagged");
   chk_brown_flag : assert property (hw_err[0] |=> sts[`TXE_STS_BROWN])
      else $error("brownout not flagged");
   chk_flag_sticky : assert property (!sts_wr |=> (sts & $past(sts)) == $past(sts))
      else $error("flag lost without clear");
   chk_pa_off : assert property (fail |=> !pa_enable)
      else $error("amplifier on during failure");

   cov_halt   : cover property (tx_act ##1 state == txe_pkg::TXE_HALT);
   cov_sync   : cover property (in_sync && chip_en && half);
   cov_parity : cover property (par_bad != '0);
endmodule : txe_top

/* tb/txe_host.sv */
// host model: places one data bit after each bit request of the transmitter
`timescale 1ns/1ns
module txe_host (
   // clock
   input  wire logic        clock,
   // control from the bench
   input  wire logic        active,
   input  wire logic        slow,
   input  wire logic [15:0] pattern,
   // link to the transmitter
   input  wire logic        clock_output_pin,
   output logic             sdio
);
   logic       prev_ck = 1'b0;
   logic       late    = 1'b0;
   logic [3:0] cnt     = 4'h0;
   wire logic  rise    = clock_output_pin & ~prev_ck;

   initial sdio = 1'b0;

   always @(posedge clock)
   begin
      prev_ck <= clock_output_pin;
      late    <= rise;
      if (!active)
      begin
         cnt  <= 4'h0;
         // released line wanders, so a stale bit is never taken for data
         sdio <= ~sdio;
      end
      else if (slow ? late : rise)
      begin
         // slow answer comes one clock later, still well inside half a bit
         sdio <= pattern[cnt];
         cnt  <= cnt + 4'h1;
      end
   end
endmodule : txe_host

/* tb/tb.sv */
// testbench: register port, async and sync transmission, line codes, fail-safe flags
`timescale 1ns/1ns
module tb;
   localparam logic [15:0] PAT = 16'h358e;
   localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h07, 8'h07, 8'h00, 8'h00, 8'h01, 8'h00};
   logic       clock;
   logic       rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       bench_sdio;
   logic       host_sdio;
   logic       active;
   logic       slow;
   logic       ck_pin;
   logic [3:0] fail;
   logic       mod_data;
   logic       gauss_en;
   logic       ask_shape_en;
   logic       pa_enable;
   logic       irq;
   logic       prev_ck;
   logic       c1 [0:31];
   logic       c2 [0:31];
   int         n_fail;
   int         n_compared;
   int         idx;
   int         run;
   int         hi_len;
   wire logic  sdio_line = active ? host_sdio : bench_sdio;

   txe_top #(.DIV_W(8)) DUT (
      .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sdio_in(sdio_line), .clock_output_pin(ck_pin), .brownout_in(fail[0]), .lock_err_in(fail[1]),
      .cal_err_in(fail[2]), .cfg_upset_in(fail[3]), .mod_data(mod_data), .gauss_en(gauss_en),
      .ask_shape_en(ask_shape_en), .pa_enable(pa_enable), .irq(irq));

   txe_host HOST (.clock(clock), .active(active), .slow(slow), .pattern(PAT),
                  .clock_output_pin(ck_pin), .sdio(host_sdio));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // chips are taken in the last cycle of each half of a bit
   always @(posedge clock)
   begin
      if (!active)
         idx = 0;
      else if (ck_pin && !prev_ck && idx < 32)
      begin
         c1[idx] = mod_data;
         idx = idx + 1;
      end
      else if (!ck_pin && prev_ck && idx > 0)
         c2[idx-1] = mod_data;
      if (ck_pin)
         run = run + 1;
      else if (run != 0)
      begin
         hi_len = run;
         run = 0;
      end
      prev_ck = ck_pin;
   end

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      @(negedge clock);
      check(name, rdata & m, exp);
   endtask : rd_chk

   // descrambled chip of pair j, used to predict the generator from its own history
   function automatic logic scr(input int j, input logic inv);
      return c1[j] ^ inv ^ PAT[(j-2)%16];
   endfunction : scr

   // pair k carries the bit that the host gave at request k-2
   task automatic sync_run(input logic [7:0] enc, input logic sl);
      int   k;
      logic b;
      logic pb;
      logic p;
      logic e1;
      logic m;
      wr_reg(3'h1, enc);
      slow   <= sl;
      active <= 1'b1;
      wr_reg(3'h0, 8'h03);
      for (k = 0; k < 800 && idx < 27; k++)
         @(posedge clock);
      if (idx < 27)
      begin
         n_fail++;
         finish_test();
      end
      check("pa_sync", {7'h00, pa_enable}, 8'h01);
      check("req_high", 8'(hi_len), 8'h08);
      wr_reg(3'h0, 8'h00);
      active <= 1'b0;
      for (k = 11; k < 26; k++)
      begin
         b  = PAT[(k-2)%16];
         pb = PAT[(k-3)%16];
         p  = c2[k-1] ^ enc[3];
         case (enc[2:0])
            3'h0: {e1, m} = {b, 1'b0};
            3'h1: {e1, m} = {b, 1'b1};
            3'h2: {e1, m} = {b ? p : ~p, 1'b1};
            3'h3: {e1, m} = {~p, ~b};
            3'h4: {e1, m} = {~p, b};
            3'h5: {e1, m} = {(!b && !pb) ? ~p : p, b};
            default: {e1, m} = {b ^ scr(k-5, enc[3]) ^ scr(k-9, enc[3]), 1'b0};
         endcase
         check("chips", {6'h00, c1[k] ^ enc[3], c2[k] ^ enc[3]}, {6'h00, e1, e1 ^ m});
      end
   endtask : sync_run

   initial
   begin
      rst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      bench_sdio = 1'b0;
      active = 1'b0;
      slow = 1'b0;
      fail = 4'h0;
      prev_ck = 1'b0;
      n_fail = 0;
      n_compared = 0;
      idx = 0;
      run = 0;
      hi_len = 0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wr_reg(3'h7, 8'hff);
      for (int a = 0; a < 8; a++)
         rd_chk("reset_value", a[2:0], 8'hff, RSTV[a]);
      $display("test reset done");

      wr_reg(3'h3, 8'h01);
      wr_reg(3'h0, 8'h1d);
      wr_reg(3'h3, 8'h01);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock);
         bench_sdio <= PAT[i];
         repeat (3) @(posedge clock);
         @(negedge clock);
         check("async_data", {7'h00, mod_data}, {7'h00, PAT[i]});
      end
      check("shaping", {6'h00, gauss_en, ask_shape_en}, 8'h03);
      check("clk_half", 8'(hi_len), 8'h02);
      rd_chk("status_clean", 3'h4, 8'hff, 8'h00);
      rd_chk("state_async", 3'h6, 8'hef, 8'h22);
      wr_reg(3'h0, 8'h00);
      $display("test async done");

      for (int c = 0; c < 8; c++)
      begin
         sync_run((c < 7) ? 8'(c) : 8'h09, c[0]);
         $display("test sync code %0d done", c);
      end

      // lock error stays masked, so only its irq differs
      wr_reg(3'h5, 8'h0d);
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(3'h0, 8'h01);
         @(posedge clock);
         fail <= 4'(1 << i);
         repeat (2) @(posedge clock);
         fail <= 4'h0;
         repeat (4) @(posedge clock);
         @(negedge clock);
         check("pa_off", {7'h00, pa_enable}, 8'h00);
         check("irq", {7'h00, irq}, {7'h00, i != 1});
         rd_chk("status_set", 3'h4, 8'hff, 8'(1 << i));
         wr_reg(3'h0, 8'h00);
         wr_reg(3'h3, 8'h07);
         rd_chk("still_halt", 3'h6, 8'hff, 8'h08);
         wr_reg(3'h4, 8'(1 << i));
         rd_chk("status_clear", 3'h4, 8'hff, 8'h00);
         check("irq_clear", {7'h00, irq}, 8'h00);
         rd_chk("state_idle", 3'h6, 8'hff, 8'h01);
      end
      $display("test fail-safe done");
      finish_test();
   end
endmodule : tb
